//--- hw/timer16_capture_compare.sv
/*
  Input capture and two output compare channels of a 16-bit timer.
  Assumes a counter unit outside that supplies the count, a timer tick, top and bottom
  strobes and a strobe for each CPU write of the count; the capture pin and comparator
  output arrive asynchronously; the waveform generator reads the compare outputs.
*/
// Function
// - Matching edge copies counter to capture register
// - Capture flag set with the load
// - Flag plus enable requests IRQ; ack clears
// - Writing one clears capture flag
// - Low-byte read latches high byte
// - Capture register writable only as top
// - Pin default; comparator when select set
// - Source switch may capture; software clears
// - Both inputs share synchroniser and edge detector
// - Filter passes level after four agreeing samples
// - Filter adds four cycles, system clock
// - Capture input off when capture is top
// - Port output writes reach capture path
// - New capture always overwrites the register
// - Sixteen-bit compare sets flag next tick
// - Compare flag IRQ; ack or one clears
// - Channel A may define the counter top
// - PWM modes buffer, update at top/bottom
// - CPU reaches buffer or active register
// - Compare high read returns register directly
// - High write to temp; low commits
// - Force strobe acts like match, no flag
// - Counter write blocks next-tick match
// - Action zero leaves compare output alone
`timescale 1ns/1ns
`include "timer16_cc_defines.svh"
module timer16_capture_compare #(
  parameter int FILTER_DEPTH = `CC_FILTER_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire timer16_cc_pkg::reg_req_t regReq,
  output logic [7:0] regRdata_q,
  // Counter unit
  input wire timer16_cc_pkg::counter_in_t counterIn,
  // Trigger sources, asynchronous
  input wire logic capture_input_pin,
  input wire logic comparator_output,
  input wire logic portOutCapture,
  input wire logic portDriveCapture,
  // Interrupt acknowledges, one-cycle pulses
  input wire logic captureAck,
  input wire logic compareAckA,
  input wire logic compareAckB,
  // Interrupt requests
  output logic captureIrq_q,
  output logic compareIrqA_q,
  output logic compareIrqB_q,
  // Waveform generator
  output logic compare_outputA_q,
  output logic compare_outputB_q,
  output logic [15:0] topValue_q,
  output logic captureIsTop_q
);
  // Control registers
  logic [7:0] ctrl_q;
  logic [3:0] actions_q;
  logic [2:0] irqEn_q;
  logic [2:0] flags_q;
  logic [7:0] temp_q;
  logic [15:0] capture_register_q;
  logic [15:0] cmpActA_q;
  logic [15:0] cmpActB_q;
  logic [15:0] cmpBufA_q;
  logic [15:0] cmpBufB_q;
  logic [3:0] mode;

  assign mode = ctrl_q[`CC_CTRL_MODE_MSB:`CC_CTRL_MODE_LSB];

  // Modes that take the capture register as top
  function automatic logic capIsTop(input logic [3:0] m);
    capIsTop = (m == `CC_MODE_CTC_CAP) || (m == `CC_MODE_FAST_CAP) ||
      (m == `CC_MODE_PFC_CAP) || (m == `CC_MODE_PC_CAP);
  endfunction : capIsTop

  // Non-PWM: normal and the two clear-on-match modes
  function automatic logic nonPwm(input logic [3:0] m);
    nonPwm = (m == `CC_MODE_NORMAL) || (m == `CC_MODE_CTC_A) || (m == `CC_MODE_CTC_CAP);
  endfunction : nonPwm

  // New compare output level for an action setting
  function automatic logic applyAction(input logic cur, input logic [1:0] act);
    case (act)
      timer16_cc_pkg::ACT_TOGGLE: applyAction = ~cur;
      timer16_cc_pkg::ACT_CLEAR: applyAction = 1'b0;
      timer16_cc_pkg::ACT_SET: applyAction = 1'b1;
      default: applyAction = cur;
    endcase
  endfunction : applyAction

  logic wrHit;
  logic rdHit;
  assign wrHit = regReq.wr;
  assign rdHit = regReq.rd;

  // Trigger select; port output drives pin path when enabled
  logic pinLevel;
  logic rawTrigger;
  assign pinLevel = portDriveCapture ? portOutCapture : capture_input_pin;
  assign rawTrigger = ctrl_q[`CC_CTRL_CMPSEL] ? comparator_output : pinLevel;

  // Shared two-stage synchroniser for either source
  logic syncA_q;
  logic syncB_q;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end
    else
    begin
      syncA_q <= rawTrigger;
      syncB_q <= syncA_q;
    end
  end

  // Newest sample plus three held ones; a full extra stage would cost a fifth cycle
  logic [FILTER_DEPTH-2:0] filtPipe_q;
  logic filtLevel_q;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      filtPipe_q <= '0;
      filtLevel_q <= 1'b0;
    end
    else
    begin
      filtPipe_q <= {filtPipe_q[FILTER_DEPTH-3:0], syncB_q};
      if (&{filtPipe_q, syncB_q})
        filtLevel_q <= 1'b1;
      else if (~|{filtPipe_q, syncB_q})
        filtLevel_q <= 1'b0;
    end
  end

  // Edge detector; gated off while capture register is top
  logic edgeIn;
  logic edgePrev_q;
  logic captureEvent;
  assign edgeIn = ctrl_q[`CC_CTRL_FILTER] ? filtLevel_q : syncB_q;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      edgePrev_q <= 1'b0;
    else
      edgePrev_q <= edgeIn;
  end
  // A source switch changes edgeIn and may legitimately fire a capture
  assign captureEvent = !capIsTop(mode) &&
    (ctrl_q[`CC_CTRL_EDGE] ? (edgeIn && !edgePrev_q) : (!edgeIn && edgePrev_q));

  // Capture register: events overwrite, CPU writes only when it is top
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      capture_register_q <= `CC_WORD_ZERO;
    else if (captureEvent)
      capture_register_q <= counterIn.value;
    else if (wrHit && regReq.addr == `CC_ADDR_CAP_LO && capIsTop(mode))
      capture_register_q <= {temp_q, regReq.wdata};
  end

  // Shared temp byte: high writes load it, capture low reads latch it
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      temp_q <= `CC_BYTE_ZERO;
    else if (wrHit && (regReq.addr == `CC_ADDR_CAP_HI || regReq.addr == `CC_ADDR_CMPA_HI ||
        regReq.addr == `CC_ADDR_CMPB_HI))
      temp_q <= regReq.wdata;
    else if (rdHit && regReq.addr == `CC_ADDR_CAP_LO)
      temp_q <= capture_register_q[15:8];
  end

  // Control, action and enable registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ctrl_q <= `CC_BYTE_ZERO;
      actions_q <= 4'h0;
      irqEn_q <= 3'h0;
    end
    else if (wrHit)
    begin
      if (regReq.addr == `CC_ADDR_CTRL)
        ctrl_q <= regReq.wdata;
      else if (regReq.addr == `CC_ADDR_ACTION)
        actions_q <= regReq.wdata[3:0];
      else if (regReq.addr == `CC_ADDR_IRQEN)
        irqEn_q <= regReq.wdata[2:0];
    end
  end

  // Compare match with block after counter write; flag a tick later
  logic blockNext_q;
  logic pendA_q;
  logic pendB_q;
  logic matchA;
  logic matchB;
  assign matchA = (counterIn.value == cmpActA_q) && !blockNext_q;
  assign matchB = (counterIn.value == cmpActB_q) && !blockNext_q;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      blockNext_q <= 1'b0;
    else if (counterIn.cpuWrite)
      blockNext_q <= 1'b1;
    else if (counterIn.tick)
      blockNext_q <= 1'b0;
  end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pendA_q <= 1'b0;
      pendB_q <= 1'b0;
    end
    else if (counterIn.tick)
    begin
      pendA_q <= matchA;
      pendB_q <= matchB;
    end
  end
  logic setA;
  logic setB;
  assign setA = counterIn.tick && pendA_q;
  assign setB = counterIn.tick && pendB_q;

  // Flags: hardware set wins over software or acknowledge clear
  logic [2:0] clrMask;
  assign clrMask = (wrHit && regReq.addr == `CC_ADDR_FLAGS) ? regReq.wdata[2:0] : 3'h0;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      flags_q <= 3'h0;
    else
    begin
      if (captureEvent)
        flags_q[`CC_FLAG_CAP] <= 1'b1;
      else if (clrMask[`CC_FLAG_CAP] || captureAck)
        flags_q[`CC_FLAG_CAP] <= 1'b0;
      if (setA)
        flags_q[`CC_FLAG_CMPA] <= 1'b1;
      else if (clrMask[`CC_FLAG_CMPA] || compareAckA)
        flags_q[`CC_FLAG_CMPA] <= 1'b0;
      if (setB)
        flags_q[`CC_FLAG_CMPB] <= 1'b1;
      else if (clrMask[`CC_FLAG_CMPB] || compareAckB)
        flags_q[`CC_FLAG_CMPB] <= 1'b0;
    end
  end

  // Interrupt requests from flags and enables
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      captureIrq_q <= 1'b0;
      compareIrqA_q <= 1'b0;
      compareIrqB_q <= 1'b0;
    end
    else
    begin
      captureIrq_q <= flags_q[`CC_FLAG_CAP] && irqEn_q[`CC_FLAG_CAP];
      compareIrqA_q <= flags_q[`CC_FLAG_CMPA] && irqEn_q[`CC_FLAG_CMPA];
      compareIrqB_q <= flags_q[`CC_FLAG_CMPB] && irqEn_q[`CC_FLAG_CMPB];
    end
  end

  // Compare registers: buffered in PWM modes, direct otherwise; counter never writes them
  logic wrCmpA;
  logic wrCmpB;
  assign wrCmpA = wrHit && regReq.addr == `CC_ADDR_CMPA_LO;
  assign wrCmpB = wrHit && regReq.addr == `CC_ADDR_CMPB_LO;
  logic reload;
  // Update at bottom for CC_MODE_PFC_CAP and CC_MODE_PWM_A_TOP_2, at top for the others
  assign reload = (mode == `CC_MODE_PFC_CAP || mode == `CC_MODE_PWM_A_TOP_2) ?
    counterIn.atBottom : counterIn.atTop;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cmpBufA_q <= `CC_WORD_ZERO;
      cmpBufB_q <= `CC_WORD_ZERO;
    end
    else
    begin
      if (wrCmpA)
        cmpBufA_q <= {temp_q, regReq.wdata};
      if (wrCmpB)
        cmpBufB_q <= {temp_q, regReq.wdata};
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cmpActA_q <= `CC_WORD_ZERO;
      cmpActB_q <= `CC_WORD_ZERO;
    end
    else if (nonPwm(mode))
    begin
      if (wrCmpA)
        cmpActA_q <= {temp_q, regReq.wdata};
      if (wrCmpB)
        cmpActB_q <= {temp_q, regReq.wdata};
    end
    else if (reload)
    begin
      cmpActA_q <= cmpBufA_q;
      cmpActB_q <= cmpBufB_q;
    end
  end

  // Top value for the counter: channel A or capture register
  logic aIsTop;
  assign aIsTop = (mode == `CC_MODE_CTC_A) || (mode == `CC_MODE_PWM_A_TOP_1) ||
    (mode == `CC_MODE_PWM_A_TOP_2) || (mode == `CC_MODE_PWM_A_TOP_3);
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      topValue_q <= `CC_WORD_ZERO;
      captureIsTop_q <= 1'b0;
    end
    else
    begin
      topValue_q <= aIsTop ? cmpActA_q : capture_register_q;
      captureIsTop_q <= capIsTop(mode);
    end
  end

  // Compare outputs in non-PWM modes; force acts as a match without a flag
  logic forceA;
  logic forceB;
  assign forceA = wrHit && regReq.addr == `CC_ADDR_FORCE && regReq.wdata[0] && nonPwm(mode);
  assign forceB = wrHit && regReq.addr == `CC_ADDR_FORCE && regReq.wdata[1] && nonPwm(mode);
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      compare_outputA_q <= 1'b0;
      compare_outputB_q <= 1'b0;
    end
    else
    begin
      if (forceA || (setA && nonPwm(mode)))
        compare_outputA_q <= applyAction(compare_outputA_q, actions_q[1:0]);
      if (forceB || (setB && nonPwm(mode)))
        compare_outputB_q <= applyAction(compare_outputB_q, actions_q[3:2]);
    end
  end

  // Read data one cycle after the strobe; zero otherwise
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !rdHit)
      regRdata_q <= `CC_BYTE_ZERO;
    else if (regReq.addr == `CC_ADDR_CAP_LO)
      regRdata_q <= capture_register_q[7:0];
    else if (regReq.addr == `CC_ADDR_CAP_HI)
      regRdata_q <= temp_q;
    else if (regReq.addr == `CC_ADDR_CMPA_LO)
      regRdata_q <= nonPwm(mode) ? cmpActA_q[7:0] : cmpBufA_q[7:0];
    else if (regReq.addr == `CC_ADDR_CMPA_HI)
      regRdata_q <= nonPwm(mode) ? cmpActA_q[15:8] : cmpBufA_q[15:8];
    else if (regReq.addr == `CC_ADDR_CMPB_LO)
      regRdata_q <= nonPwm(mode) ? cmpActB_q[7:0] : cmpBufB_q[7:0];
    else if (regReq.addr == `CC_ADDR_CMPB_HI)
      regRdata_q <= nonPwm(mode) ? cmpActB_q[15:8] : cmpBufB_q[15:8];
    else if (regReq.addr == `CC_ADDR_CTRL)
      regRdata_q <= ctrl_q;
    else if (regReq.addr == `CC_ADDR_ACTION)
      regRdata_q <= {4'h0, actions_q};
    else if (regReq.addr == `CC_ADDR_FLAGS)
      regRdata_q <= {5'h00, flags_q};
    else if (regReq.addr == `CC_ADDR_IRQEN)
      regRdata_q <= {5'h00, irqEn_q};
    else if (regReq.addr == `CC_ADDR_STATUS)
      regRdata_q <= {6'h00, filtLevel_q, edgeIn};
    else
      regRdata_q <= `CC_BYTE_ZERO;
  end
endmodule : timer16_capture_compare

//--- shared/timer16_cc_defines.svh
/*
  Offsets, field positions and reset values for the timer capture/compare block.
  Assumes an 8-bit register port with byte offsets 0x00 to 0x0F.
*/
`ifndef TIMER16_CC_DEFINES_SVH
`define TIMER16_CC_DEFINES_SVH
`define CC_ADDR_CAP_LO 4'h0
`define CC_ADDR_CAP_HI 4'h1
`define CC_ADDR_CMPA_LO 4'h2
`define CC_ADDR_CMPA_HI 4'h3
`define CC_ADDR_CMPB_LO 4'h4
`define CC_ADDR_CMPB_HI 4'h5
`define CC_ADDR_CTRL 4'h6
`define CC_ADDR_ACTION 4'h7
`define CC_ADDR_FLAGS 4'h8
`define CC_ADDR_IRQEN 4'h9
`define CC_ADDR_FORCE 4'hA
`define CC_ADDR_STATUS 4'hB
`define CC_CTRL_MODE_LSB 0
`define CC_CTRL_MODE_MSB 3
`define CC_CTRL_EDGE 4
`define CC_CTRL_FILTER 5
`define CC_CTRL_CMPSEL 6
`define CC_FLAG_CAP 0
`define CC_FLAG_CMPA 1
`define CC_FLAG_CMPB 2
`define CC_ACT_A_LSB 0
`define CC_ACT_B_LSB 2
`define CC_MODE_NORMAL 4'h0
`define CC_MODE_CTC_A 4'h4
`define CC_MODE_CTC_CAP 4'hC
`define CC_MODE_FAST_CAP 4'hE
`define CC_MODE_PFC_CAP 4'h8
`define CC_MODE_PC_CAP 4'hA
`define CC_MODE_PWM_A_TOP_1 4'hF
`define CC_MODE_PWM_A_TOP_2 4'h9
`define CC_MODE_PWM_A_TOP_3 4'hB
`define CC_FILTER_DEPTH 4
`define CC_BYTE_ZERO 8'h00
`define CC_WORD_ZERO 16'h0000
`endif

//--- shared/timer16_cc_pkg.sv
/*
  Types for the timer capture/compare block.
  Assumes the defines header sits beside it on the include path.
*/
package timer16_cc_pkg;
  // One CPU register access
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  // Counter-unit handshake into the block
  typedef struct packed {
    logic [15:0] value;
    logic tick;
    logic atTop;
    logic atBottom;
    logic cpuWrite;
  } counter_in_t;
  typedef enum logic [1:0] {ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_SET} output_action_sel_t;
endpackage : timer16_cc_pkg

//--- testbench/timer16_cc_monitor.sv
/*
  Checker for the timer capture/compare block, bound to its top module.
  Assumes one clock domain and the register map of the defines header.
*/
`timescale 1ns/1ns
module timer16_cc_monitor #(
  parameter int FILTER_DEPTH = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Inputs of the block
  input wire timer16_cc_pkg::reg_req_t regReq,
  input wire timer16_cc_pkg::counter_in_t counterIn,
  input wire logic captureAck,
  input wire logic compareAckA,
  input wire logic compareAckB,
  // Outputs of the block
  input wire logic [7:0] regRdata_q,
  input wire logic captureIrq_q,
  input wire logic compareIrqA_q,
  input wire logic compareIrqB_q,
  input wire logic compare_outputA_q,
  input wire logic compare_outputB_q,
  input wire logic captureIsTop_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Decoded writes for the flags and force strobes; enable and control writes are decoded inline below
  wire flagWr = regReq.wr && regReq.addr == 4'h8;
  wire forceWr = regReq.wr && regReq.addr == 4'hA;
  property p_rdIdle;
    !$past(regReq.rd) |-> regRdata_q == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
  property p_capClear;
    flagWr && regReq.wdata[0] |-> ##2 !captureIrq_q;
  endproperty
  a_capClear: assert property (p_capClear) else $error("capture flag kept");
  property p_capAck;
    captureAck |-> ##2 !captureIrq_q;
  endproperty
  a_capAck: assert property (p_capAck) else $error("capture ack ignored");
  property p_capMask;
    regReq.wr && regReq.addr == 4'h9 && !regReq.wdata[0] |-> ##2 (!captureIrq_q)[*2];
  endproperty
  a_capMask: assert property (p_capMask) else $error("masked capture irq");
  property p_cmpClrA;
    compareAckA || (flagWr && regReq.wdata[1]) |-> ##2 !compareIrqA_q;
  endproperty
  a_cmpClrA: assert property (p_cmpClrA) else $error("compare A flag kept");
  property p_cmpClrB;
    compareAckB || (flagWr && regReq.wdata[2]) |-> ##2 !compareIrqB_q;
  endproperty
  a_cmpClrB: assert property (p_cmpClrB) else $error("compare B flag kept");
  property p_cmpTick;
    $rose(compareIrqA_q) |-> $past(counterIn.tick, 2);
  endproperty
  a_cmpTick: assert property (p_cmpTick) else $error("compare flag off tick");
  property p_outA;
    $changed(compare_outputA_q) |-> $past(counterIn.tick) || $past(forceWr && regReq.wdata[0]);
  endproperty
  a_outA: assert property (p_outA) else $error("output A moved alone");
  property p_outB;
    $changed(compare_outputB_q) |-> $past(counterIn.tick) || $past(forceWr && regReq.wdata[1]);
  endproperty
  a_outB: assert property (p_outB) else $error("output B moved alone");
  property p_topMode;
    regReq.wr && regReq.addr == 4'h6 |->
      ##2 captureIsTop_q == ($past(regReq.wdata[3], 2) && !$past(regReq.wdata[0], 2));
  endproperty
  a_topMode: assert property (p_topMode) else $error("capture top flag wrong");
endmodule : timer16_cc_monitor
bind timer16_capture_compare timer16_cc_monitor #(.FILTER_DEPTH(FILTER_DEPTH)) mon_u (
  .core_clk, .sys_rst, .regReq, .counterIn, .captureAck, .compareAckA, .compareAckB,
  .regRdata_q, .captureIrq_q, .compareIrqA_q, .compareIrqB_q, .compare_outputA_q,
  .compare_outputB_q, .captureIsTop_q
);

//--- testbench/counter_model.sv
/*
  Behavioural counter unit feeding the capture/compare block.
  Assumes the bench sets the tick enable, loads and wrap at top.
*/
`timescale 1ns/1ns
module counter_model #(
  parameter int TICK_DIV = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Control from the bench
  input wire logic tickEn,
  input wire logic load,
  input wire logic [15:0] loadVal,
  input wire logic wrapEn,
  input wire logic [15:0] topValue_q,
  // Count towards the block
  output timer16_cc_pkg::counter_in_t counterIn
);
  int div;
  // Count moves only on the tick edge or a load, so it is steady while compared
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      counterIn <= '0;
      div <= 0;
    end
    else
    begin
      div <= (div == TICK_DIV - 1) ? 0 : div + 1;
      counterIn.tick <= tickEn && div == 0;
      counterIn.atTop <= tickEn && div == 0 && wrapEn && counterIn.value == topValue_q;
      counterIn.atBottom <= tickEn && div == 0 && counterIn.value == 16'h0000;
      counterIn.cpuWrite <= load;
      // A CPU write wins over counting
      if (load)
        counterIn.value <= loadVal;
      else if (counterIn.tick)
        counterIn.value <= counterIn.atTop ? 16'h0000 : counterIn.value + 16'h0001;
    end
  end
endmodule : counter_model

//--- testbench/tb_top.sv
/*
  Self-checking bench for the timer capture/compare block.
  Assumes the package, the counter model and the bound checker are compiled first.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  // Clock, reset and bench state
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 97602;
  logic [7:0] expQ[$];
  logic [15:0] v;
  logic [15:0] w;
  logic [15:0] ca;
  logic [15:0] cb;
  // Design ports
  timer16_cc_pkg::reg_req_t regReq = '0;
  timer16_cc_pkg::counter_in_t counterIn;
  logic [7:0] regRdata_q;
  logic pin = 1'b0;
  logic comp = 1'b0;
  logic portOut = 1'b0;
  logic portDrv = 1'b0;
  logic [2:0] acks = 3'h0;
  wire [2:0] irqs;
  logic outA;
  logic outB;
  logic [15:0] topValue_q;
  logic captureIsTop_q;
  // Counter model controls
  logic tickEn = 1'b0;
  logic load = 1'b0;
  logic wrapEn = 1'b0;
  logic [15:0] loadVal = 16'h0000;
  timer16_capture_compare #(.FILTER_DEPTH(4)) dut_u (
    .core_clk, .sys_rst, .regReq, .regRdata_q, .counterIn,
    .capture_input_pin(pin), .comparator_output(comp),
    .portOutCapture(portOut), .portDriveCapture(portDrv),
    .captureAck(acks[0]), .compareAckA(acks[1]), .compareAckB(acks[2]),
    .captureIrq_q(irqs[0]), .compareIrqA_q(irqs[1]), .compareIrqB_q(irqs[2]),
    .compare_outputA_q(outA), .compare_outputB_q(outB), .topValue_q, .captureIsTop_q
  );
  counter_model #(.TICK_DIV(2)) model_u (
    .core_clk, .sys_rst, .tickEn, .load, .loadVal, .wrapEn, .topValue_q, .counterIn
  );
  always #5 core_clk = ~core_clk;
  // Hang guard, well above the longest scenario
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk)
    if (regReq.rd === 1'b1)
    begin
      #1;
      `CHK(regRdata_q, expQ.pop_front())
    end
  // One access, then an idle cycle so no strobe is assigned twice at one edge
  task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic wn);
    regReq <= '{a, d, wn, !wn};
    @(posedge core_clk);
    regReq <= '0;
    @(posedge core_clk);
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expQ.push_back(e);
    bus(a, 8'h00, 1'b0);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic setCount(input logic [15:0] x);
    loadVal <= x;
    load <= 1'b1;
    @(posedge core_clk);
    load <= 1'b0;
    @(posedge core_clk);
  endtask : setCount
  task automatic ack(input int i);
    acks[i] <= 1'b1;
    @(posedge core_clk);
    acks[i] <= 1'b0;
    @(posedge core_clk);
  endtask : ack
  // Bounded wait for one interrupt line to reach a level
  task automatic waitIrq(input int i, input logic e, input int n);
    for (int k = 0; k < n && irqs[i] !== e; k++) settle(1);
    `CHK(irqs[i], e)
  endtask : waitIrq
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(4'h8, 8'h00);
    wr(4'h9, 8'h07);
    // Pin, port bit and comparator, each on a frozen random count
    for (int s = 0; s < 3; s++)
    begin
      v = 16'($random(seed));
      setCount(v);
      portDrv <= (s == 1);
      wr(4'h6, {1'b0, s == 2, 2'b01, 4'h0});
      settle(6);
      wr(4'h8, 8'h01);
      waitIrq(0, 1'b0, 4);
      if (s == 0) pin <= 1'b1;
      else if (s == 1) portOut <= 1'b1;
      else comp <= 1'b1;
      waitIrq(0, 1'b1, 12);
      rd(4'h0, v[7:0]);
      rd(4'h1, v[15:8]);
    end
    // Enable off masks the pending request, back on restores it
    wr(4'h9, 8'h06);
    waitIrq(0, 1'b0, 4);
    wr(4'h9, 8'h07);
    waitIrq(0, 1'b1, 4);
    ack(0);
    waitIrq(0, 1'b0, 4);
    // Falling edge, then a second capture overwrites the unread first one
    wr(4'h6, 8'h00);
    v = 16'($random(seed));
    setCount(v);
    pin <= 1'b0;
    waitIrq(0, 1'b1, 12);
    w = 16'($random(seed));
    setCount(w);
    wr(4'h6, 8'h10);
    pin <= 1'b1;
    settle(8);
    rd(4'h0, w[7:0]);
    rd(4'h1, w[15:8]);
    // Filter: a short glitch is dropped, a steady level is late
    wr(4'h8, 8'h01);
    wr(4'h6, 8'h30);
    pin <= 1'b0;
    settle(2);
    pin <= 1'b1;
    settle(12);
    `CHK(irqs[0], 1'b0)
    pin <= 1'b0;
    settle(10);
    // Two sync stages plus four filter cycles: request shows eight cycles on
    pin <= 1'b1;
    settle(5);
    `CHK(irqs[0], 1'b0)
    settle(3);
    `CHK(irqs[0], 1'b1)
    // Capture register as top: writable, input off
    wr(4'h8, 8'h01);
    wr(4'h6, 8'h1C);
    wr(4'h1, v[15:8]);
    wr(4'h0, v[7:0]);
    settle(1);
    `CHK(topValue_q, v)
    `CHK(captureIsTop_q, 1'b1)
    pin <= 1'b0;
    settle(12);
    pin <= 1'b1;
    settle(12);
    `CHK(irqs[0], 1'b0)
    wr(4'h6, 8'h10);
    wr(4'h1, w[15:8]);
    wr(4'h0, w[7:0]);
    rd(4'h0, v[7:0]);
    // Compare channels in normal mode: A toggles, B sets
    ca = (16'($random(seed)) & 16'h00FF) + 16'h0005;
    cb = ca + 16'h0004;
    wr(4'h7, 8'h0D);
    setCount(ca - 16'h0005);
    wr(4'h3, ca[15:8]);
    wr(4'h2, ca[7:0]);
    wr(4'h5, cb[15:8]);
    wr(4'h4, cb[7:0]);
    rd(4'h0, v[7:0]);
    rd(4'h3, ca[15:8]);
    rd(4'h2, ca[7:0]);
    tickEn <= 1'b1;
    waitIrq(1, 1'b1, 40);
    `CHK(outA, 1'b1)
    waitIrq(2, 1'b1, 40);
    `CHK(outB, 1'b1)
    tickEn <= 1'b0;
    ack(2);
    waitIrq(2, 1'b0, 4);
    wr(4'h8, 8'h02);
    waitIrq(1, 1'b0, 4);
    // Force: A clears, B with action zero holds, no flag
    wr(4'h7, 8'h02);
    wr(4'hA, 8'h03);
    settle(2);
    `CHK(outA, 1'b0)
    `CHK(outB, 1'b1)
    `CHK(irqs[1], 1'b0)
    // Counter written to the match value: that match is lost
    setCount(ca);
    tickEn <= 1'b1;
    settle(6);
    tickEn <= 1'b0;
    `CHK(irqs[1], 1'b0)
    // PWM with A as top: new value waits for the top
    wrapEn <= 1'b1;
    wr(4'h6, 8'h1F);
    setCount(16'h0000);
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h30);
    `CHK(topValue_q, ca)
    rd(4'h2, 8'h30);
    tickEn <= 1'b1;
    for (int k = 0; k < 800 && topValue_q !== 16'h0030; k++) settle(1);
    `CHK(topValue_q, 16'h0030)
    tally_and_finish();
  end
endmodule : tb_top
